// [shared/config_bank_pkg.sv]
// constants for the processor configuration register bank
// assumes a 64-bit register access port inside the core clock domain
package config_bank_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 64;
   // register offsets in the configuration register space
   localparam logic [11:0] OFS_BUS_FREQUENCY_CONFIG     = 12'h02C;
   localparam logic [11:0] OFS_MICROCODE_LOAD_TRIGGER   = 12'h079;
   localparam logic [11:0] OFS_MICROCODE_SIGNATURE      = 12'h08B;
   localparam logic [11:0] OFS_RANGE_TYPE_CAPABILITIES  = 12'h0FE;
   localparam logic [11:0] OFS_FAST_CALL_CODE_SEGMENT   = 12'h174;
   localparam logic [11:0] OFS_FAST_CALL_STACK_POINTER  = 12'h175;
   localparam logic [11:0] OFS_FAST_CALL_ENTRY_POINT    = 12'h176;
   localparam logic [11:0] OFS_ERROR_CHECK_CAPABILITIES = 12'h179;
   localparam logic [11:0] OFS_ERROR_CHECK_STATE        = 12'h17A;
   localparam logic [11:0] OFS_ERROR_CHECK_ENABLE       = 12'h17B;
   localparam logic [11:0] OFS_ERROR_SAVED_ACCUMULATOR  = 12'h180;
   localparam logic [11:0] OFS_ERROR_SAVED_BASE         = 12'h181;
   localparam logic [11:0] OFS_ERROR_SAVED_COUNT        = 12'h182;
   // bus speed field, older model layout
   localparam int unsigned BUS_SPEED_LSB = 21;
   localparam int unsigned BUS_SPEED_MSB = 23;
   localparam logic [2:0]  BUS_SPEED_100MHZ = 3'h0;
   localparam logic [3:0]  MODEL_LAYOUT_LIMIT = 4'h2;
   // signature field position
   localparam int unsigned SIGNATURE_LSB = 32;
   // saved general register field width
   localparam int unsigned SAVED_W = 32;
   localparam logic [63:0] ZERO64 = 64'h0;
endpackage

// [logic/config_register_bank.sv]
// processor configuration register bank: 64-bit registers reached by
// register read and write instructions in the core clock domain
// assumes one access per cycle; reads are answered on the next edge
// Behaviour
// R1: bus speed field bits 23:21, 100 MHz
// R2: that layout only when model below two
// R3: write to trigger starts microcode load
// R4: signature in upper half after identify
// R5: signature stays zero without loaded update
// R6: software zeroes signature before identify
// R7: code segment register for fast calls
// R8: stack pointer register for fast calls
// R9: entry point register for fast entry
// R10: read-only error check capabilities
// R11: read-only error check state
// R12: writable error check enable register
// R13: accumulator captured on error
// R14: base register captured on error
// R15: count register captured on error
// R16: saved fields readable, writable only zero
// R17: reserved bits read zero, ignore writes
`timescale 1ns/1ps
module config_register_bank (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [11:0] i_addr,
   input  wire logic [63:0] i_wdata,
   output logic      [63:0] o_rdata,
   output logic             o_rd_valid,
   output logic             o_rd_error,
   input  wire logic [3:0]  i_model,
   input  wire logic [2:0]  i_bus_speed,
   input  wire logic        i_identify,
   input  wire logic [31:0] i_identify_accumulator,
   input  wire logic        i_update_loaded,
   input  wire logic [31:0] i_update_signature,
   output logic             o_microcode_load_start,
   output logic [63:0]      o_microcode_load_address,
   input  wire logic [63:0] i_error_capabilities,
   input  wire logic [63:0] i_error_state,
   output logic [63:0]      o_error_check_enable,
   input  wire logic        i_error_event,
   input  wire logic [31:0] i_accumulator_register,
   input  wire logic [31:0] i_base_register,
   input  wire logic [31:0] i_count_register,
   output logic [63:0]      o_fast_call_code_segment,
   output logic [63:0]      o_fast_call_stack_pointer,
   output logic [63:0]      o_fast_call_entry_point
);
   typedef enum logic [1:0] {
      LOAD_IDLE  = 2'h0,
      LOAD_START = 2'h1
   } load_state_type;

   load_state_type  load_state;
   load_state_type  next_load_state;
   logic [31:0]     signature;
   logic [31:0]     next_signature;
   logic [63:0]     load_address;
   logic [63:0]     next_load_address;
   logic [63:0]     code_segment;
   logic [63:0]     next_code_segment;
   logic [63:0]     stack_pointer;
   logic [63:0]     next_stack_pointer;
   logic [63:0]     entry_point;
   logic [63:0]     next_entry_point;
   logic [63:0]     check_enable;
   logic [63:0]     next_check_enable;
   logic [31:0]     saved_acc;
   logic [31:0]     next_saved_acc;
   logic [31:0]     saved_base;
   logic [31:0]     next_saved_base;
   logic [31:0]     saved_count;
   logic [31:0]     next_saved_count;
   logic [63:0]     rdata;
   logic [63:0]     next_rdata;
   logic            rd_valid;
   logic            next_rd_valid;
   logic            rd_error;
   logic            next_rd_error;
   logic [63:0]     freq_word;

   // R1: bus speed field, R2: older model layout only
   always_comb begin
      freq_word = config_bank_pkg::ZERO64;
      if (i_model < config_bank_pkg::MODEL_LAYOUT_LIMIT) begin
         freq_word[config_bank_pkg::BUS_SPEED_MSB:config_bank_pkg::BUS_SPEED_LSB] =
            i_bus_speed;
      end
   end

   // register state next values
   always_comb begin
      next_load_state   = LOAD_IDLE;
      next_load_address = load_address;
      next_signature    = signature;
      next_code_segment = code_segment;
      next_stack_pointer = stack_pointer;
      next_entry_point  = entry_point;
      next_check_enable = check_enable;
      next_saved_acc    = saved_acc;
      next_saved_base   = saved_base;
      next_saved_count  = saved_count;
      if (i_wr) begin
         case (i_addr)
            // R3: write triggers update load
            config_bank_pkg::OFS_MICROCODE_LOAD_TRIGGER: begin
               next_load_state   = LOAD_START;
               next_load_address = i_wdata;
            end
            // R6: software may preload zero
            config_bank_pkg::OFS_MICROCODE_SIGNATURE: begin
               next_signature = i_wdata[63:config_bank_pkg::SIGNATURE_LSB];
            end
            // R7: code segment storage
            config_bank_pkg::OFS_FAST_CALL_CODE_SEGMENT: begin
               next_code_segment = i_wdata;
            end
            // R8: stack pointer storage
            config_bank_pkg::OFS_FAST_CALL_STACK_POINTER: begin
               next_stack_pointer = i_wdata;
            end
            // R9: entry point storage
            config_bank_pkg::OFS_FAST_CALL_ENTRY_POINT: begin
               next_entry_point = i_wdata;
            end
            // R12: enable control
            config_bank_pkg::OFS_ERROR_CHECK_ENABLE: begin
               next_check_enable = i_wdata;
            end
            // R16: only zero clears saved state
            config_bank_pkg::OFS_ERROR_SAVED_ACCUMULATOR: begin
               if (i_wdata[31:0] == 32'h0) next_saved_acc = 32'h0;
            end
            config_bank_pkg::OFS_ERROR_SAVED_BASE: begin
               if (i_wdata[31:0] == 32'h0) next_saved_base = 32'h0;
            end
            config_bank_pkg::OFS_ERROR_SAVED_COUNT: begin
               if (i_wdata[31:0] == 32'h0) next_saved_count = 32'h0;
            end
            default: begin
               next_load_state = LOAD_IDLE;
            end
         endcase
      end
      // R4: identify with accumulator one, R5: zero kept without update
      if (i_identify && (i_identify_accumulator == 32'h1) && i_update_loaded) begin
         next_signature = i_update_signature;
      end
      // R13: R14: R15: capture wins over clear
      if (i_error_event) begin
         next_saved_acc   = i_accumulator_register;
         next_saved_base  = i_base_register;
         next_saved_count = i_count_register;
      end
   end

   // read path next values
   always_comb begin
      next_rdata    = config_bank_pkg::ZERO64;
      next_rd_valid = i_rd;
      next_rd_error = 1'b0;
      if (i_rd) begin
         case (i_addr)
            config_bank_pkg::OFS_BUS_FREQUENCY_CONFIG: begin
               next_rdata = freq_word;
            end
            config_bank_pkg::OFS_MICROCODE_LOAD_TRIGGER: begin
               next_rdata = load_address;
            end
            // R4: R17: lower half reads zero
            config_bank_pkg::OFS_MICROCODE_SIGNATURE: begin
               next_rdata = {signature, 32'h0};
            end
            config_bank_pkg::OFS_RANGE_TYPE_CAPABILITIES: begin
               next_rdata = config_bank_pkg::ZERO64;
            end
            config_bank_pkg::OFS_FAST_CALL_CODE_SEGMENT: begin
               next_rdata = code_segment;
            end
            config_bank_pkg::OFS_FAST_CALL_STACK_POINTER: begin
               next_rdata = stack_pointer;
            end
            config_bank_pkg::OFS_FAST_CALL_ENTRY_POINT: begin
               next_rdata = entry_point;
            end
            // R10: capabilities read only
            config_bank_pkg::OFS_ERROR_CHECK_CAPABILITIES: begin
               next_rdata = i_error_capabilities;
            end
            // R11: state read only
            config_bank_pkg::OFS_ERROR_CHECK_STATE: begin
               next_rdata = i_error_state;
            end
            config_bank_pkg::OFS_ERROR_CHECK_ENABLE: begin
               next_rdata = check_enable;
            end
            // R16: R17: saved fields, upper half zero
            config_bank_pkg::OFS_ERROR_SAVED_ACCUMULATOR: begin
               next_rdata = {32'h0, saved_acc};
            end
            config_bank_pkg::OFS_ERROR_SAVED_BASE: begin
               next_rdata = {32'h0, saved_base};
            end
            config_bank_pkg::OFS_ERROR_SAVED_COUNT: begin
               next_rdata = {32'h0, saved_count};
            end
            default: begin
               next_rd_error = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         load_state    <= LOAD_IDLE;
         load_address  <= 64'h0;
         signature     <= 32'h0;
         code_segment  <= 64'h0;
         stack_pointer <= 64'h0;
         entry_point   <= 64'h0;
         check_enable  <= 64'h0;
         saved_acc     <= 32'h0;
         saved_base    <= 32'h0;
         saved_count   <= 32'h0;
         rdata         <= 64'h0;
         rd_valid      <= 1'b0;
         rd_error      <= 1'b0;
      end else begin
         load_state    <= next_load_state;
         load_address  <= next_load_address;
         signature     <= next_signature;
         code_segment  <= next_code_segment;
         stack_pointer <= next_stack_pointer;
         entry_point   <= next_entry_point;
         check_enable  <= next_check_enable;
         saved_acc     <= next_saved_acc;
         saved_base    <= next_saved_base;
         saved_count   <= next_saved_count;
         rdata         <= next_rdata;
         rd_valid      <= next_rd_valid;
         rd_error      <= next_rd_error;
      end
   end

   assign o_rdata                   = rdata;
   assign o_rd_valid                = rd_valid;
   assign o_rd_error                = rd_error;
   assign o_microcode_load_start    = (load_state == LOAD_START);
   assign o_microcode_load_address  = load_address;
   assign o_error_check_enable      = check_enable;
   assign o_fast_call_code_segment  = code_segment;
   assign o_fast_call_stack_pointer = stack_pointer;
   assign o_fast_call_entry_point   = entry_point;

   property p_load_start;
      @(posedge i_clk) disable iff (i_rst)
      (i_wr && i_addr == config_bank_pkg::OFS_MICROCODE_LOAD_TRIGGER)
         |=> o_microcode_load_start && o_microcode_load_address == $past(i_wdata);
   endproperty
   a_load_start: assert property (p_load_start) else $error("load not started"); // R3

   property p_signature_load;
      @(posedge i_clk) disable iff (i_rst)
      (i_identify && i_identify_accumulator == 32'h1 && i_update_loaded && !i_error_event)
         ##1 (i_rd && i_addr == config_bank_pkg::OFS_MICROCODE_SIGNATURE && !i_identify)
         |=> o_rdata == {$past(i_update_signature, 2), 32'h0};
   endproperty
   a_signature_load: assert property (p_signature_load) else $error("bad signature"); // R4

   property p_signature_zero;
      @(posedge i_clk) disable iff (i_rst)
      (i_wr && i_addr == config_bank_pkg::OFS_MICROCODE_SIGNATURE
         && i_wdata[63:32] == 32'h0 && !(i_identify && i_update_loaded))
         ##1 (i_rd && i_addr == config_bank_pkg::OFS_MICROCODE_SIGNATURE
         && !(i_identify && i_update_loaded)) |=> o_rdata == 64'h0;
   endproperty
   a_signature_zero: assert property (p_signature_zero) else $error("signature not zero"); // R5

   property p_code_segment;
      @(posedge i_clk) disable iff (i_rst)
      (i_wr && i_addr == config_bank_pkg::OFS_FAST_CALL_CODE_SEGMENT)
         |=> o_fast_call_code_segment == $past(i_wdata);
   endproperty
   a_code_segment: assert property (p_code_segment) else $error("code segment lost"); // R7

   property p_stack_pointer;
      @(posedge i_clk) disable iff (i_rst)
      (i_wr && i_addr == config_bank_pkg::OFS_FAST_CALL_STACK_POINTER)
         |=> o_fast_call_stack_pointer == $past(i_wdata);
   endproperty
   a_stack_pointer: assert property (p_stack_pointer) else $error("stack pointer lost"); // R8

   property p_entry_point;
      @(posedge i_clk) disable iff (i_rst)
      (i_wr && i_addr == config_bank_pkg::OFS_FAST_CALL_ENTRY_POINT)
         |=> o_fast_call_entry_point == $past(i_wdata);
   endproperty
   a_entry_point: assert property (p_entry_point) else $error("entry point lost"); // R9

   property p_enable;
      @(posedge i_clk) disable iff (i_rst)
      (i_wr && i_addr == config_bank_pkg::OFS_ERROR_CHECK_ENABLE)
         |=> o_error_check_enable == $past(i_wdata);
   endproperty
   a_enable: assert property (p_enable) else $error("enable not stored"); // R12

   property p_capture;
      @(posedge i_clk) disable iff (i_rst)
      i_error_event ##1 (i_rd && i_addr == config_bank_pkg::OFS_ERROR_SAVED_ACCUMULATOR
         && !i_error_event && !i_wr) |=> o_rdata == {32'h0, $past(i_accumulator_register, 2)};
   endproperty
   a_capture: assert property (p_capture) else $error("accumulator not saved"); // R13

   property p_freq;
      @(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == config_bank_pkg::OFS_BUS_FREQUENCY_CONFIG)
         |=> o_rdata[20:0] == 21'h0 && o_rdata[63:24] == 40'h0 && o_rd_valid;
   endproperty
   a_freq: assert property (p_freq) else $error("reserved bits set"); // R17

   property p_unmapped;
      @(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == 12'h000) |=> o_rd_error && o_rdata == 64'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted"); // R17

   c_load: cover property (@(posedge i_clk) disable iff (i_rst) o_microcode_load_start);
   c_error: cover property (@(posedge i_clk) disable iff (i_rst) i_error_event ##1 i_rd);
   c_ident: cover property (@(posedge i_clk) disable iff (i_rst)
      i_identify && i_update_loaded);
endmodule

// [testbench/testbench.sv]
// self-checking bench for the configuration register bank
// assumes the bank answers reads one edge later and drives all outputs 0 out of reset
`timescale 1ns/1ps
module testbench;
   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [11:0] i_addr = 12'h000;
   logic [63:0] i_wdata = 64'h0;
   logic [63:0] o_rdata;
   logic        o_rd_valid;
   logic        o_rd_error;
   logic [3:0]  i_model = 4'h0;
   logic [2:0]  i_bus_speed = 3'h0;
   logic        i_identify = 1'b0;
   logic [31:0] i_identify_accumulator = 32'h0;
   logic        i_update_loaded = 1'b0;
   logic [31:0] i_update_signature = 32'h0;
   logic        o_microcode_load_start;
   logic [63:0] o_microcode_load_address;
   logic [63:0] i_error_capabilities = 64'hC0FFEE0012345678;
   logic [63:0] i_error_state = 64'h00000000000A0005;
   logic [63:0] o_error_check_enable;
   logic        i_error_event = 1'b0;
   logic [31:0] i_accumulator_register = 32'h0;
   logic [31:0] i_base_register = 32'h0;
   logic [31:0] i_count_register = 32'h0;
   logic [63:0] o_fast_call_code_segment;
   logic [63:0] o_fast_call_stack_pointer;
   logic [63:0] o_fast_call_entry_point;
   int          n_errors = 0;
   int          checks_done = 0;
   int          cycles = 0;

   config_register_bank dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
      .o_rd_error(o_rd_error), .i_model(i_model), .i_bus_speed(i_bus_speed),
      .i_identify(i_identify), .i_identify_accumulator(i_identify_accumulator),
      .i_update_loaded(i_update_loaded), .i_update_signature(i_update_signature),
      .o_microcode_load_start(o_microcode_load_start),
      .o_microcode_load_address(o_microcode_load_address),
      .i_error_capabilities(i_error_capabilities), .i_error_state(i_error_state),
      .o_error_check_enable(o_error_check_enable), .i_error_event(i_error_event),
      .i_accumulator_register(i_accumulator_register), .i_base_register(i_base_register),
      .i_count_register(i_count_register), .o_fast_call_code_segment(o_fast_call_code_segment),
      .o_fast_call_stack_pointer(o_fast_call_stack_pointer),
      .o_fast_call_entry_point(o_fast_call_entry_point));

   always #10 i_clk = ~i_clk;

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // cut a hang short
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic step;
      @(posedge i_clk);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [63:0] d);
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      step();
      i_wr = 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [63:0] exp, input logic err);
      i_rd = 1'b1;
      i_addr = a;
      step();
      i_rd = 1'b0;
      chk1(o_rd_valid, 1'b1);
      chk1(o_rd_error, err);
      chk64(o_rdata, exp);
      step();
      chk1(o_rd_valid, 1'b0);
   endtask

   task automatic identify(input logic [31:0] acc);
      i_identify = 1'b1;
      i_identify_accumulator = acc;
      step();
      i_identify = 1'b0;
   endtask

   initial begin
      logic [63:0] pat;
      repeat (8) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      chk64(o_fast_call_code_segment, 64'h0);
      chk64(o_error_check_enable, 64'h0);
      // fast call registers, read back and driven out
      for (int k = 0; k < 3; k++) begin
         pat = 64'hA5A5000000000000 | 64'(k + 1) << 8 | 64'h3C;
         wr(config_bank_pkg::OFS_FAST_CALL_CODE_SEGMENT + 12'(k), pat);
         rd(config_bank_pkg::OFS_FAST_CALL_CODE_SEGMENT + 12'(k), pat, 1'b0);
      end
      chk64(o_fast_call_code_segment, 64'hA5A500000000013C);
      chk64(o_fast_call_stack_pointer, 64'hA5A500000000023C);
      chk64(o_fast_call_entry_point, 64'hA5A500000000033C);
      wr(config_bank_pkg::OFS_ERROR_CHECK_ENABLE, 64'hFFFFFFFFFFFFFFFF);
      chk64(o_error_check_enable, 64'hFFFFFFFFFFFFFFFF);
      rd(config_bank_pkg::OFS_ERROR_CHECK_ENABLE, 64'hFFFFFFFFFFFFFFFF, 1'b0);
      // read-only registers ignore writes
      wr(config_bank_pkg::OFS_ERROR_CHECK_CAPABILITIES, 64'h0);
      rd(config_bank_pkg::OFS_ERROR_CHECK_CAPABILITIES, i_error_capabilities, 1'b0);
      wr(config_bank_pkg::OFS_ERROR_CHECK_STATE, 64'h0);
      rd(config_bank_pkg::OFS_ERROR_CHECK_STATE, i_error_state, 1'b0);
      rd(config_bank_pkg::OFS_RANGE_TYPE_CAPABILITIES, 64'h0, 1'b0);
      rd(12'h100, 64'h0, 1'b1);
      rd(12'h000, 64'h0, 1'b1);
      // bus speed field across the model boundary
      for (int m = 0; m < 4; m++) begin
         for (int s = 0; s < 8; s++) begin
            i_model = 4'(m);
            i_bus_speed = 3'(s);
            pat = (m < 2) ? 64'(s) << 21 : 64'h0;
            rd(config_bank_pkg::OFS_BUS_FREQUENCY_CONFIG, pat, 1'b0);
         end
      end
      i_model = 4'h0;
      wr(config_bank_pkg::OFS_BUS_FREQUENCY_CONFIG, 64'hFFFFFFFFFFFFFFFF);
      rd(config_bank_pkg::OFS_BUS_FREQUENCY_CONFIG, 64'h0000000000E00000, 1'b0);
      // load trigger pulse
      i_wr = 1'b1;
      i_addr = config_bank_pkg::OFS_MICROCODE_LOAD_TRIGGER;
      i_wdata = 64'h00000000FEED0000;
      step();
      i_wr = 1'b0;
      chk1(o_microcode_load_start, 1'b1);
      chk64(o_microcode_load_address, 64'h00000000FEED0000);
      step();
      chk1(o_microcode_load_start, 1'b0);
      // signature after identify
      wr(config_bank_pkg::OFS_MICROCODE_SIGNATURE, 64'h0);
      rd(config_bank_pkg::OFS_MICROCODE_SIGNATURE, 64'h0, 1'b0);
      identify(32'h1);
      rd(config_bank_pkg::OFS_MICROCODE_SIGNATURE, 64'h0, 1'b0);
      i_update_loaded = 1'b1;
      i_update_signature = 32'h0000002E;
      identify(32'h2);
      rd(config_bank_pkg::OFS_MICROCODE_SIGNATURE, 64'h0, 1'b0);
      identify(32'h1);
      rd(config_bank_pkg::OFS_MICROCODE_SIGNATURE, 64'h0000002E00000000, 1'b0);
      wr(config_bank_pkg::OFS_MICROCODE_SIGNATURE, 64'h12345678FFFFFFFF);
      rd(config_bank_pkg::OFS_MICROCODE_SIGNATURE, 64'h1234567800000000, 1'b0);
      // error capture, nonzero write ignored, zero write clears
      i_accumulator_register = 32'h11112222;
      i_base_register = 32'h33334444;
      i_count_register = 32'h55556666;
      i_error_event = 1'b1;
      step();
      i_error_event = 1'b0;
      for (int k = 0; k < 3; k++) begin
         pat = (k == 0) ? 64'h11112222 : (k == 1) ? 64'h33334444 : 64'h55556666;
         rd(config_bank_pkg::OFS_ERROR_SAVED_ACCUMULATOR + 12'(k), pat, 1'b0);
         wr(config_bank_pkg::OFS_ERROR_SAVED_ACCUMULATOR + 12'(k), 64'h1);
         rd(config_bank_pkg::OFS_ERROR_SAVED_ACCUMULATOR + 12'(k), pat, 1'b0);
         wr(config_bank_pkg::OFS_ERROR_SAVED_ACCUMULATOR + 12'(k), 64'h0);
         rd(config_bank_pkg::OFS_ERROR_SAVED_ACCUMULATOR + 12'(k), 64'h0, 1'b0);
      end
      give_verdict();
   end
endmodule
